/* rtl/bceor_regs.sv */
/*
 * Clock gating control, system error cause flags, retry alias options and delayed transaction timer.
 * Assumes configuration accesses arrive as single-cycle strobes synchronous to CORE_CLK.
 */
`timescale 1ns/1ps
`default_nettype none
module bceor_regs #(
	parameter int MASTER_TIMEOUT_CLKS = bceor_pkg::MT_CLKS_DFLT
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// Configuration access
	input wire bceor_pkg::bceor_cfg_req_t CFG_REQ,
	output logic [31:0] CFG_RDATA,
	output logic CFG_RVALID,
	// System error causes
	input wire logic [7:0] SERR_CAUSE,
	input wire logic [7:0] SERR_CAUSE_DISABLE,
	input wire logic SERR_ENABLE,
	output logic PRIMARY_SYSTEM_ERROR_OUT_N,
	// Delayed transaction timer
	input wire logic DT_PENDING,
	output logic DT_TIMEOUT,
	// Retry command matching
	input wire logic [3:0] RETRY_CMD,
	input wire logic [3:0] STORED_CMD,
	output logic RETRY_MATCH,
	// Secondary clocks
	output logic [9:0] SECONDARY_CLOCK_OUTPUT
);
	localparam int TW = $clog2(MASTER_TIMEOUT_CLKS + 1);
	localparam logic [TW-1:0] T_LAST = TW'(MASTER_TIMEOUT_CLKS - 1);

	logic [15:0] clk_ctrl;
	logic [7:0] cause;
	logic [15:0] option;
	logic hit_clk;
	logic hit_opt;
	logic wr_clk;
	logic wr_opt;
	logic [7:0] cause_set;
	logic [7:0] cause_clr;
	logic [9:0] clk_en;
	logic [9:0] en_hold;
	logic phase;
	logic [TW-1:0] t_cnt;
	logic t_expired;
	logic t_fire;

	// Byte-lane merge of a 16-bit field under a write mask
	function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] be, input logic [15:0] wmask);
		logic [15:0] lanes;
		lanes = {{8{be[1]}}, {8{be[0]}}} & wmask;
		return (old & ~lanes) | (wd & lanes);
	endfunction

	// Exact or aliased retry command comparison
	function automatic logic cmd_match(input logic [3:0] retry, input logic [3:0] stored,
		input logic rd_alias, input logic wr_alias);
		logic m;
		m = (retry == stored);
		if (rd_alias && stored == bceor_pkg::PLAIN_MEMORY_READ_CMD &&
			(retry == bceor_pkg::MEMORY_READ_LINE_CMD || retry == bceor_pkg::MEMORY_READ_MULTIPLE_CMD))
		begin
			m = 1'b1;
		end
		if (wr_alias && stored == bceor_pkg::PLAIN_MEMORY_WRITE_CMD &&
			retry == bceor_pkg::WRITE_INVALIDATE_CMD)
		begin
			m = 1'b1;
		end
		return m;
	endfunction

	// Address decode
	assign hit_clk = (CFG_REQ.addr[7:2] == bceor_pkg::CLK_CTRL_OFF[7:2]);
	assign hit_opt = (CFG_REQ.addr[7:2] == bceor_pkg::OPTION_OFF[7:2]);
	assign wr_clk = CFG_REQ.wr && hit_clk;
	assign wr_opt = CFG_REQ.wr && hit_opt;

	// Clock control word, reserved bits never stored
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			clk_ctrl <= bceor_pkg::CLK_CTRL_RST;
		else if (wr_clk)
			clk_ctrl <= be_merge(clk_ctrl, CFG_REQ.wdata[15:0], CFG_REQ.be[1:0], bceor_pkg::CLK_CTRL_WMASK);
	end

	// Port option word, only the alias bits stored
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			option <= bceor_pkg::OPTION_RST;
		else if (wr_opt)
			option <= be_merge(option, CFG_REQ.wdata[15:0], CFG_REQ.be[1:0], bceor_pkg::OPTION_WMASK);
	end

	// Causes that really drive the error output
	always_comb
	begin
		cause_set = SERR_CAUSE;
		cause_set[bceor_pkg::CAUSE_DT_TIMEOUT] = SERR_CAUSE[bceor_pkg::CAUSE_DT_TIMEOUT] | t_fire;
		cause_set = cause_set & ~SERR_CAUSE_DISABLE & {8{SERR_ENABLE}};
		cause_clr = (wr_clk && CFG_REQ.be[2]) ? CFG_REQ.wdata[23:16] : 8'h00;
	end

	// Sticky cause flags, a new event wins over a clear
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			cause <= bceor_pkg::CAUSE_RST;
		else
			cause <= (cause & ~cause_clr) | cause_set;
	end

	// Error output pulse
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			PRIMARY_SYSTEM_ERROR_OUT_N <= 1'b1;
		else
			PRIMARY_SYSTEM_ERROR_OUT_N <= ~|cause_set;
	end

	// Delayed transaction master timer
	assign t_fire = DT_PENDING && !t_expired && (t_cnt == T_LAST);

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			t_cnt <= '0;
			t_expired <= 1'b0;
		end
		else if (!DT_PENDING)
		begin
			t_cnt <= '0;
			t_expired <= 1'b0;
		end
		else if (t_fire)
		begin
			t_cnt <= '0;
			t_expired <= 1'b1;
		end
		else if (!t_expired)
			t_cnt <= t_cnt + TW'(1);
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			DT_TIMEOUT <= 1'b0;
		else
			DT_TIMEOUT <= t_fire;
	end

	// Retry match
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			RETRY_MATCH <= 1'b0;
		else
			RETRY_MATCH <= cmd_match(RETRY_CMD, STORED_CMD,
				option[bceor_pkg::OPT_RD_ALIAS_BIT], option[bceor_pkg::OPT_WR_ALIAS_BIT]);
	end

	// Read path
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			CFG_RDATA <= bceor_pkg::RDATA_RST;
			CFG_RVALID <= 1'b0;
		end
		else
		begin
			CFG_RVALID <= CFG_REQ.rd;
			if (CFG_REQ.rd && hit_clk)
				CFG_RDATA <= {8'h00, cause, clk_ctrl & bceor_pkg::CLK_CTRL_WMASK};
			else if (CFG_REQ.rd && hit_opt)
				CFG_RDATA <= {16'h0000, option & bceor_pkg::OPTION_WMASK};
			else if (CFG_REQ.rd)
				CFG_RDATA <= bceor_pkg::RDATA_RST;
		end
	end

	// Per-output enable decode
	always_comb
	begin
		clk_en = '0;
		for (int i = 0; i < bceor_pkg::CLK_PAIR_NUM; i++)
		begin
			clk_en[i] = ~&clk_ctrl[2*i +: 2];
		end
		for (int i = bceor_pkg::CLK_PAIR_NUM; i < bceor_pkg::CLK_NUM; i++)
		begin
			clk_en[i] = ~clk_ctrl[bceor_pkg::CLK_SINGLE_LSB + i - bceor_pkg::CLK_PAIR_NUM];
		end
	end

	// Half-rate clock enable
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			phase <= 1'b0;
		else
			phase <= ~phase;
	end

	// Enable sampled only on the edge that drives the outputs low, so pulses are always whole
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			en_hold <= '0;
		else if (phase)
			en_hold <= clk_en;
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			SECONDARY_CLOCK_OUTPUT <= '0;
		else
			SECONDARY_CLOCK_OUTPUT <= phase ? 10'h000 : en_hold;
	end

	// Checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	a_clk_pair_stop: assert property ((clk_ctrl[1:0] == 2'b11)[*4] |-> !SECONDARY_CLOCK_OUTPUT[0])
		else $error("paired clock 0 runs while disabled");
	a_clk_pair_run: assert property ((clk_ctrl[1:0] != 2'b11)[*4] |-> ##[0:1] SECONDARY_CLOCK_OUTPUT[0])
		else $error("paired clock 0 not running while enabled");
	a_clk_single_stop: assert property (clk_ctrl[8][*4] |-> !SECONDARY_CLOCK_OUTPUT[4])
		else $error("clock 4 not held low while disabled");
	a_clk_no_runt: assert property (SECONDARY_CLOCK_OUTPUT[0] |-> !$past(SECONDARY_CLOCK_OUTPUT[0]) ##1 !SECONDARY_CLOCK_OUTPUT[0])
		else $error("secondary clock pulse malformed");
	a_rsvd_clk_read: assert property (CFG_REQ.rd && hit_clk |=> CFG_RVALID && CFG_RDATA[15:14] == 2'b00)
		else $error("reserved clock bits read nonzero");
	a_opt_bit0_read: assert property (CFG_REQ.rd && hit_opt |=> CFG_RVALID && !CFG_RDATA[0])
		else $error("option bit 0 read nonzero");
	a_cause_set: assert property (|cause_set |=> ((cause & $past(cause_set)) == $past(cause_set)) && !PRIMARY_SYSTEM_ERROR_OUT_N)
		else $error("cause flag not set with error output");
	a_cause_clear: assert property (wr_clk && CFG_REQ.be[2] && CFG_REQ.wdata[16] && !cause_set[0] |=> !cause[0])
		else $error("address parity flag not cleared");
	a_cause_only_serr: assert property ($rose(cause[5]) |-> $past(SERR_ENABLE) && $past(SERR_CAUSE[5]) && !$past(SERR_CAUSE_DISABLE[5]))
		else $error("flag set without error output");
	a_cause_hold_zero: assert property (wr_clk && CFG_REQ.be[2] && CFG_REQ.wdata[23:16] == 8'h00 |=> cause == ($past(cause) | $past(cause_set)))
		else $error("zero write disturbed flags");
	a_alias_read: assert property (option[1] && STORED_CMD == 4'h6 && RETRY_CMD == 4'he |=> RETRY_MATCH)
		else $error("read alias not matched");
	a_exact_write: assert property (!option[2] && STORED_CMD == 4'h7 && RETRY_CMD == 4'hf |=> !RETRY_MATCH)
		else $error("write matched without alias");
	a_timeout_count: assert property (DT_TIMEOUT |-> $past(t_cnt) == T_LAST && $past(DT_PENDING))
		else $error("master timeout at wrong count");
	a_timeout_flag: assert property (t_fire && SERR_ENABLE && !SERR_CAUSE_DISABLE[7] |=> cause[7])
		else $error("timeout flag not set");
	a_timeout_single: assert property (DT_TIMEOUT |=> !DT_TIMEOUT)
		else $error("master timeout pulse longer than one cycle");
	a_err_idle_high: assert property (cause_set == 8'h00 |=> PRIMARY_SYSTEM_ERROR_OUT_N)
		else $error("error output low without cause");
	a_clk_single_run: assert property ((!clk_ctrl[13])[*4] |-> ##[0:1] SECONDARY_CLOCK_OUTPUT[9])
		else $error("clock 9 not running while enabled");
	a_clk_pair3_stop: assert property ((clk_ctrl[7:6] == 2'b11)[*4] |-> !SECONDARY_CLOCK_OUTPUT[3])
		else $error("paired clock 3 runs while disabled");
	a_timeout_w1c: assert property (wr_clk && CFG_REQ.be[2] && CFG_REQ.wdata[23] && !cause_set[7] |=> !cause[7])
		else $error("timeout flag not cleared");
	a_cause_sticky: assert property (cause[2] && !(wr_clk && CFG_REQ.be[2] && CFG_REQ.wdata[18]) |=> cause[2])
		else $error("non-delivery flag lost without clear");
	a_addr_par_gate: assert property ($rose(cause[0]) |-> $past(SERR_ENABLE) && !$past(SERR_CAUSE_DISABLE[0]))
		else $error("address parity flag set while suppressed");
	a_alias_multiple: assert property (option[1] && STORED_CMD == bceor_pkg::PLAIN_MEMORY_READ_CMD &&
		RETRY_CMD == bceor_pkg::MEMORY_READ_MULTIPLE_CMD |=> RETRY_MATCH)
		else $error("read multiple alias not matched");
	a_exact_read: assert property (!option[1] && STORED_CMD == bceor_pkg::PLAIN_MEMORY_READ_CMD &&
		RETRY_CMD != bceor_pkg::PLAIN_MEMORY_READ_CMD |=> !RETRY_MATCH)
		else $error("read matched without alias");
	a_alias_write: assert property (option[2] && STORED_CMD == bceor_pkg::PLAIN_MEMORY_WRITE_CMD &&
		RETRY_CMD == bceor_pkg::WRITE_INVALIDATE_CMD |=> RETRY_MATCH)
		else $error("write alias not matched");

	c_clock_stop: cover property ($fell(en_hold[9]));
	c_serr_event: cover property (!PRIMARY_SYSTEM_ERROR_OUT_N);
	c_timeout: cover property (DT_TIMEOUT);
	c_set_and_clear: cover property (wr_clk && CFG_REQ.be[2] && |(cause_set & CFG_REQ.wdata[23:16]));
endmodule // bceor_regs
`default_nettype wire

/* include/bceor_pkg.sv */
/*
 * Constants and carrier types for the bridge clock gating, error cause and port option registers.
 * Assumes a 32-bit configuration access path with byte enables and dword-aligned byte addresses.
 */
`default_nettype none
package bceor_pkg;
	// Register offsets, byte addresses
	localparam logic [7:0] CLK_CTRL_OFF = 8'h68;
	localparam logic [7:0] OPTION_OFF = 8'h74;
	// Reset values
	localparam logic [15:0] CLK_CTRL_RST = 16'h0000;
	localparam logic [7:0] CAUSE_RST = 8'h00;
	localparam logic [15:0] OPTION_RST = 16'h0000;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
	// Field layout of the clock control word
	localparam int CLK_NUM = 10;
	localparam int CLK_PAIR_NUM = 4;
	localparam int CLK_SINGLE_LSB = 8;
	localparam logic [15:0] CLK_CTRL_WMASK = 16'h3fff;
	// Error cause flags sit in byte 2 of the clock control dword
	localparam int CAUSE_LSB = 16;
	localparam int CAUSE_NUM = 8;
	localparam int CAUSE_ADDR_PARITY = 0;
	localparam int CAUSE_PW_PARITY = 1;
	localparam int CAUSE_PW_NODELIV = 2;
	localparam int CAUSE_PW_TABORT = 3;
	localparam int CAUSE_PW_MABORT = 4;
	localparam int CAUSE_DW_NODELIV = 5;
	localparam int CAUSE_DR_NODATA = 6;
	localparam int CAUSE_DT_TIMEOUT = 7;
	// Port option fields
	localparam int OPT_RD_ALIAS_BIT = 1;
	localparam int OPT_WR_ALIAS_BIT = 2;
	localparam logic [15:0] OPTION_WMASK = 16'h0006;
	// Bus commands
	localparam logic [3:0] PLAIN_MEMORY_READ_CMD = 4'h6;
	localparam logic [3:0] PLAIN_MEMORY_WRITE_CMD = 4'h7;
	localparam logic [3:0] MEMORY_READ_MULTIPLE_CMD = 4'hc;
	localparam logic [3:0] MEMORY_READ_LINE_CMD = 4'he;
	localparam logic [3:0] WRITE_INVALIDATE_CMD = 4'hf;
	// Delayed transaction master timeout, in clocks
	localparam int MT_CLKS_DFLT = 32768;

	// One configuration access per cycle
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} bceor_cfg_req_t;
endpackage
`default_nettype wire

/* dv/tb_top.sv */
/*
 * Self-checking bench for the clock gating, error cause and port option registers.
 * Assumes the design top bceor_regs and the carrier types of bceor_pkg.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	bceor_pkg::bceor_cfg_req_t cfg_req = '0;
	logic [31:0] cfg_rdata;
	logic cfg_rvalid;
	logic [7:0] serr_cause = 8'h00;
	logic [7:0] serr_dis = 8'h00;
	logic serr_en = 1'b0;
	logic err_n;
	logic dt_pending = 1'b0;
	logic dt_timeout;
	logic [3:0] retry_cmd = 4'h0;
	logic [3:0] stored_cmd = 4'h0;
	logic retry_match;
	logic [9:0] sclk;
	int n_mismatch = 0;
	int tests_run = 0;

	always #2.5 core_clk = ~core_clk;

	bceor_regs #(.MASTER_TIMEOUT_CLKS(16)) uut (.CORE_CLK(core_clk), .RST_N(rst_n), .CFG_REQ(cfg_req),
		.CFG_RDATA(cfg_rdata), .CFG_RVALID(cfg_rvalid), .SERR_CAUSE(serr_cause),
		.SERR_CAUSE_DISABLE(serr_dis), .SERR_ENABLE(serr_en), .PRIMARY_SYSTEM_ERROR_OUT_N(err_n),
		.DT_PENDING(dt_pending), .DT_TIMEOUT(dt_timeout), .RETRY_CMD(retry_cmd),
		.STORED_CMD(stored_cmd), .RETRY_MATCH(retry_match), .SECONDARY_CLOCK_OUTPUT(sclk));

	task automatic tally_and_finish;
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge core_clk);
		cfg_req <= {1'b1, 1'b0, a, be, d};
		@(posedge core_clk);
		cfg_req <= '0;
	endtask

	task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		cfg_req <= {1'b0, 1'b1, a, 4'hf, 32'h0000_0000};
		@(posedge core_clk);
		cfg_req <= '0;
		#1;
		`CHK(cfg_rvalid, 1'b1)
		`CHK(cfg_rdata, exp)
	endtask

	// Program the gate word, then watch which outputs pulse and that stopped ones stay low
	task automatic clk_check(input logic [15:0] ctrl, input logic [9:0] exp_run);
		logic [9:0] seen;
		cfg_wr(8'h68, 4'h3, {16'h0000, ctrl});
		cfg_rd(8'h68, {16'h0000, ctrl & 16'h3fff});
		repeat (6) @(posedge core_clk);
		seen = 10'h000;
		repeat (8)
		begin
			@(posedge core_clk);
			#1;
			seen = seen | sclk;
		end
		`CHK(seen, exp_run)
	endtask

	task automatic pulse_cause(input logic [7:0] c, input logic exp_n);
		@(posedge core_clk);
		serr_cause <= c;
		@(posedge core_clk);
		serr_cause <= 8'h00;
		#1;
		`CHK(err_n, exp_n)
	endtask

	task automatic error_flags;
		@(posedge core_clk);
		serr_en <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			pulse_cause(8'h01 << i, 1'b0);
			cfg_rd(8'h68, {8'h00, 8'h01 << i, 16'h0000});
			cfg_wr(8'h68, 4'h4, 32'h0000_0000);
			cfg_rd(8'h68, {8'h00, 8'h01 << i, 16'h0000});
			cfg_wr(8'h68, 4'h4, {8'h00, 8'h01 << i, 16'h0000});
			cfg_rd(8'h68, 32'h0000_0000);
		end
		@(posedge core_clk);
		serr_cause <= 8'h02;
		cfg_req <= {1'b1, 1'b0, 8'h68, 4'h4, 32'h0002_0000};
		@(posedge core_clk);
		serr_cause <= 8'h00;
		cfg_req <= '0;
		cfg_rd(8'h68, 32'h0002_0000);
		cfg_wr(8'h68, 4'h4, 32'h0002_0000);
		@(posedge core_clk);
		serr_dis <= 8'h01;
		pulse_cause(8'h01, 1'b1);
		@(posedge core_clk);
		serr_dis <= 8'h00;
		serr_en <= 1'b0;
		pulse_cause(8'h02, 1'b1);
		cfg_rd(8'h68, 32'h0000_0000);
	endtask

	task automatic master_timer;
		int k;
		@(posedge core_clk);
		serr_en <= 1'b1;
		dt_pending <= 1'b1;
		k = 0;
		while (dt_timeout !== 1'b1 && k < 40)
		begin
			@(posedge core_clk);
			#1;
			k++;
		end
		if (k == 40)
		begin
			n_mismatch++;
			tally_and_finish();
		end
		`CHK(k, 16)
		`CHK(err_n, 1'b0)
		@(posedge core_clk);
		dt_pending <= 1'b0;
		serr_en <= 1'b0;
		#1;
		`CHK(dt_timeout, 1'b0)
		`CHK(err_n, 1'b1)
		cfg_rd(8'h68, 32'h0080_0000);
		cfg_wr(8'h68, 4'h4, 32'h0080_0000);
	endtask

	task automatic retry(input logic [3:0] s, input logic [3:0] r, input logic exp);
		@(posedge core_clk);
		stored_cmd <= s;
		retry_cmd <= r;
		@(posedge core_clk);
		#1;
		`CHK(retry_match, exp)
	endtask

	task automatic port_options;
		cfg_rd(8'h74, 32'h0000_0000);
		retry(bceor_pkg::PLAIN_MEMORY_READ_CMD, bceor_pkg::MEMORY_READ_LINE_CMD, 1'b0);
		retry(bceor_pkg::PLAIN_MEMORY_WRITE_CMD, bceor_pkg::WRITE_INVALIDATE_CMD, 1'b0);
		retry(bceor_pkg::MEMORY_READ_LINE_CMD, bceor_pkg::MEMORY_READ_LINE_CMD, 1'b1);
		cfg_wr(8'h74, 4'hf, 32'hffff_ffff);
		cfg_rd(8'h74, 32'h0000_0006);
		retry(bceor_pkg::PLAIN_MEMORY_READ_CMD, bceor_pkg::MEMORY_READ_LINE_CMD, 1'b1);
		retry(bceor_pkg::PLAIN_MEMORY_READ_CMD, bceor_pkg::MEMORY_READ_MULTIPLE_CMD, 1'b1);
		retry(bceor_pkg::PLAIN_MEMORY_WRITE_CMD, bceor_pkg::WRITE_INVALIDATE_CMD, 1'b1);
		retry(bceor_pkg::PLAIN_MEMORY_READ_CMD, bceor_pkg::PLAIN_MEMORY_WRITE_CMD, 1'b0);
		retry(bceor_pkg::MEMORY_READ_LINE_CMD, bceor_pkg::PLAIN_MEMORY_READ_CMD, 1'b0);
		cfg_wr(8'h74, 4'hf, 32'h0000_0002);
		retry(bceor_pkg::PLAIN_MEMORY_WRITE_CMD, bceor_pkg::WRITE_INVALIDATE_CMD, 1'b0);
	endtask

	initial
	begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		cfg_rd(8'h68, 32'h0000_0000);
		cfg_rd(8'h40, 32'h0000_0000);
		clk_check(16'h0000, 10'h3ff);
		clk_check(16'hffff, 10'h000);
		clk_check(16'hfffd, 10'h001);
		clk_check(16'hfffe, 10'h001);
		clk_check(16'h00ff, 10'h3f0);
		clk_check(16'h2a00, 10'h15f);
		clk_check(16'h0000, 10'h3ff);
		error_flags();
		master_timer();
		port_options();
		tally_and_finish();
	end
endmodule // tb_top
`undef CHK
`default_nettype wire
